/* File: include/pin_ctl_pkg.sv */
// Purpose: Shared constants and types for the monitor pin control block
// Assumes: 100 MHz clock, APB register access
// Notes: Offsets are byte addresses of 32-bit words
`default_nettype none

package pin_ctl_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 100_000_000;     // Core clock rate
    localparam int WDOG_MIN_MS = 1000;       // Shortest legal timeout
    localparam int WDOG_MAX_MS = 2500;       // Longest legal timeout
    localparam int WDOG_MS = (WDOG_MIN_MS + WDOG_MAX_MS) / 2; // Chosen
    localparam int WDOG_CYCLES = WDOG_MS * (CLK_HZ / 1000);
    localparam int WDOG_CNT_W = 28;          // Holds WDOG_CYCLES
    localparam int TOGGLE_HZ = 1000;         // Toggle polling rate
    localparam int TOGGLE_HALF = CLK_HZ / (2 * TOGGLE_HZ);
    localparam int TGL_CNT_W = 16;           // Holds TOGGLE_HALF

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00; // Pins and poll mode
    localparam logic [7:0] OFS_STAT = 8'h04; // Live state
    localparam logic [7:0] OFS_IRQ = 8'h08;  // Sticky events, W1C
    localparam logic [7:0] OFS_MASK = 8'h0C; // Event enables
    localparam logic [7:0] OFS_CMD = 8'h10;  // Command strobe
    localparam logic [7:0] OFS_TEMP = 8'h14; // Temperature results
    localparam int CTRL_LEVEL = 2;           // 1 = level polling
    localparam int CMD_TEMP = 1;             // Start temperature run
    localparam int IRQ_WDOG = 0;             // Alarm raised
    localparam int IRQ_TEMP = 1;             // Temperatures stored
    localparam logic [2:0] CTRL_RST = 3'h3;  // Pins released, toggle
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [23:0] TEMP_RST = 24'h0;
    localparam logic [8:0] PIN_SYNC_RST = 9'h107; // Pins idle: released, unselected

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic done;        // One-cycle result strobe
        logic chan;        // 0 = first input, 1 = second
        logic [11:0] data; // Conversion code
    } adc_res_t;

    typedef enum logic [2:0] {
        CONV_IDLE = 3'h1,
        CONV_ONE = 3'h2,
        CONV_TWO = 3'h4
    } conv_state_t;

endpackage : pin_ctl_pkg

`default_nettype wire

/* File: rtl/pin_sync.sv */
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Inputs are unrelated to clock_i
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0 // Idle pin levels, no false edge after reset
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ************************************************************
    // Two flops per bit
    // ************************************************************
    logic [W-1:0] meta_ff; // First stage
    logic [W-1:0] hold_ff; // Second stage

    // Shift pin levels through both stages
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= INIT;
            hold_ff <= INIT;
        end
        else
        begin
            meta_ff <= d_i;
            hold_ff <= meta_ff;
        end
    end

    assign q_o = hold_ff;

endmodule : pin_sync

`default_nettype wire

/* File: rtl/wdog_timer.sv */
// Purpose: Communication watchdog counter
// Assumes: kick_i is a one-cycle pulse on clock_i
// Notes: Expiry holds until the next kick
`timescale 1ns/1ps
`default_nettype none

module wdog_timer
    import pin_ctl_pkg::*;
#(
    parameter int CYCLES = WDOG_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic kick_i,
    output logic expired_o
);

    // ************************************************************
    // Idle counter
    // ************************************************************
    logic [WDOG_CNT_W-1:0] cnt_ff; // Cycles since last command
    logic exp_ff;                  // Timed out

    // Count silence, latch expiry, restart on command
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end
        else if (kick_i)
        begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end
        else if (cnt_ff == WDOG_CNT_W'(CYCLES - 1))
        begin
            exp_ff <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign expired_o = exp_ff;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Expiry only after the full idle count
    wdog_timeout_a: assert property ($rose(exp_ff) |->
        $past(cnt_ff) == WDOG_CNT_W'(CYCLES - 1) && !$past(kick_i))
        else $error("watchdog fired at wrong count");

endmodule : wdog_timer

`default_nettype wire

/* File: rtl/monitor_pin_control_logic.sv */
// Purpose: Pin-level control of a stackable cell monitor
// Assumes: Serial framing, ADC and analog parts sit outside
// Notes: Open-drain pins use active-low output enables
`timescale 1ns/1ps
`default_nettype none

module monitor_pin_control_logic
    import pin_ctl_pkg::*;
#(
    parameter int WDOG_CYCLES_P = WDOG_CYCLES,
    parameter int TOGGLE_HALF_P = TOGGLE_HALF
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // APB slave
    input wire pin_ctl_pkg::apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // From serial frame decoder, same clock
    input wire logic cmd_valid_i,
    // Cell conversion or UV/OV check running, same clock
    input wire logic monitor_busy_i,
    // Temperature conversion handshake with the ADC
    input wire pin_ctl_pkg::adc_res_t adc_i,
    output logic temp_conv_req_o,
    output logic temp_conv_chan_o,
    // Watchdog open-drain pin
    input wire logic watchdog_alarm_n_i,
    output logic watchdog_alarm_n_o,
    output logic watchdog_alarm_n_oe_n_o,
    // General pins: bit 0 is pin one, bit 1 pin two
    input wire logic [1:0] general_pin_i,
    output logic [1:0] general_pin_o,
    output logic [1:0] general_pin_oe_n_o,
    // Address straps and stack position
    input wire logic [3:0] addr_strap_i,
    output logic [3:0] dev_addr_o,
    input wire logic top_of_stack_sel_i,
    // Serial port pins
    input wire logic chip_select_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    // Interrupt
    output logic irq_o
);

    import pin_ctl_pkg::*;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [8:0] pins_s;     // Synchronised pin levels
    logic [1:0] gpio_s;     // General pin levels
    logic wpin_s;           // Watchdog pin level
    logic [3:0] addr_s;     // Strap levels
    logic tos_s;            // Top of stack
    logic cs_n_s;           // Chip select, active low

    pin_sync #(
        .W(9),
        .INIT(PIN_SYNC_RST)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .d_i({chip_select_n_i, top_of_stack_sel_i, addr_strap_i,
              watchdog_alarm_n_i, general_pin_i}),
        .q_o(pins_s)
    );

    assign gpio_s = pins_s[1:0];
    assign wpin_s = pins_s[2];
    assign addr_s = pins_s[6:3];
    assign tos_s = pins_s[7];
    assign cs_n_s = pins_s[8];

    // ************************************************************
    // APB decode
    // ************************************************************
    logic setup;    // First cycle of a transfer
    logic access;   // Second cycle, completes
    logic addr_ok;  // Offset is mapped
    logic wr;       // Write taking effect
    logic wr_ctrl;  // Write to control
    logic wr_cmd;   // Write to command

    // Mapped offsets
    always_comb
    begin
        unique case (apb_i.paddr)
            OFS_CTRL, OFS_STAT, OFS_IRQ,
            OFS_MASK, OFS_CMD, OFS_TEMP: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign setup = apb_i.psel && !apb_i.penable;
    assign access = apb_i.psel && apb_i.penable;
    assign wr = access && apb_i.pwrite && addr_ok;
    assign wr_ctrl = wr && (apb_i.paddr == OFS_CTRL);
    assign wr_cmd = wr && (apb_i.paddr == OFS_CMD);
    assign pready_o = 1'b1;
    assign pslverr_o = access && !addr_ok;

    // ************************************************************
    // Watchdog
    // ************************************************************
    logic kick;      // Valid command seen
    logic wdog_exp;  // Alarm level
    logic wdog_d_ff; // Alarm, one cycle late

    // Serial commands and command writes both count
    assign kick = cmd_valid_i || wr_cmd;

    wdog_timer #(
        .CYCLES(WDOG_CYCLES_P)
    ) u_wdog (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .kick_i(kick),
        .expired_o(wdog_exp)
    );

    // Edge memory for the alarm event
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            wdog_d_ff <= 1'b0;
        else
            wdog_d_ff <= wdog_exp;
    end

    // Open-drain alarm: pull low while expired
    assign watchdog_alarm_n_o = 1'b0;
    assign watchdog_alarm_n_oe_n_o = !wdog_exp;

    wdog_pin_a: assert property (wdog_exp |-> !watchdog_alarm_n_oe_n_o ##2 !wpin_s)
        else $error("alarm pin not pulled low");
    kick_clear_a: assert property (kick |=> !wdog_exp ##1 !wdog_exp)
        else $error("alarm stayed after command");

    // ************************************************************
    // Control register and general pins
    // ************************************************************
    logic [2:0] ctrl_ff;  // Pin bits and poll mode
    logic [1:0] pin_lvl;  // Level seen at each pin

    // Software writes; alarm forces defaults
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            ctrl_ff <= CTRL_RST;
        else if (wdog_exp)
            ctrl_ff <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_ff <= apb_i.pwdata[2:0];
    end

    // Zero pulls low, one releases to the pull-up
    assign general_pin_o = 2'h0;
    assign general_pin_oe_n_o = ctrl_ff[1:0];

    // Pulled-down pins always read zero
    assign pin_lvl = gpio_s & ctrl_ff[1:0];

    cfg_default_a: assert property (wdog_exp |=> ctrl_ff == CTRL_RST)
        else $error("config not restored on alarm");
    pull_down_a: assert property (wr_ctrl && !apb_i.pwdata[0] && !wdog_exp
        |=> !general_pin_oe_n_o[0])
        else $error("pin one not pulled low");
    release_a: assert property (wr_ctrl && apb_i.pwdata[1]
        |=> general_pin_oe_n_o[1])
        else $error("pin two not released");

    // ************************************************************
    // Address straps
    // ************************************************************
    logic [3:0] addr_ff; // Device address

    // High strap reads one, low reads zero
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            addr_ff <= 4'h0;
        else
            addr_ff <= addr_s;
    end

    assign dev_addr_o = addr_ff;

    strap_addr_a: assert property (1'b1 |=> dev_addr_o == $past(addr_s))
        else $error("address does not follow straps");

    // ************************************************************
    // Temperature conversions
    // ************************************************************
    conv_state_t conv_ff;  // Sequencer state
    logic [23:0] temp_ff;  // Second result high, first low
    logic req_ff;          // Conversion request pulse
    logic chan_ff;         // Requested input
    logic temp_done;       // Both results stored

    assign temp_done = (conv_ff == CONV_TWO) && adc_i.done && adc_i.chan;

    // Convert input one, then input two
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            conv_ff <= CONV_IDLE;
            req_ff <= 1'b0;
            chan_ff <= 1'b0;
        end
        else
        begin
            req_ff <= 1'b0;
            unique case (conv_ff)
                CONV_IDLE:
                begin
                    // Start on command bit
                    if (wr_cmd && apb_i.pwdata[CMD_TEMP])
                    begin
                        conv_ff <= CONV_ONE;
                        req_ff <= 1'b1;
                        chan_ff <= 1'b0;
                    end
                end
                CONV_ONE:
                begin
                    // First result in, ask for the second
                    if (adc_i.done && !adc_i.chan)
                    begin
                        conv_ff <= CONV_TWO;
                        req_ff <= 1'b1;
                        chan_ff <= 1'b1;
                    end
                end
                CONV_TWO:
                begin
                    // Second result ends the run
                    if (adc_i.done && adc_i.chan)
                        conv_ff <= CONV_IDLE;
                end
            endcase
        end
    end

    // Store each result in its half of the register
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            temp_ff <= TEMP_RST;
        else if ((conv_ff == CONV_ONE) && adc_i.done && !adc_i.chan)
            temp_ff[11:0] <= adc_i.data;
        else if (temp_done)
            temp_ff[23:12] <= adc_i.data;
    end

    assign temp_conv_req_o = req_ff;
    assign temp_conv_chan_o = chan_ff;

    temp_store_a: assert property (temp_done
        |=> temp_ff[23:12] == $past(adc_i.data))
        else $error("second result not stored");

    // ************************************************************
    // Serial output polling
    // ************************************************************
    logic busy;                     // Conversion or check running
    logic sel;                      // Device selected
    logic [TGL_CNT_W-1:0] tgl_cnt_ff; // Half-period counter
    logic tgl_ff;                   // 1 kHz square wave
    logic sdo_oe_n_ff;              // Serial pin enable
    logic drive_low;                // Pull serial pin low

    assign busy = monitor_busy_i || (conv_ff != CONV_IDLE);
    assign sel = !cs_n_s;

    // Free-running toggle source
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tgl_cnt_ff <= '0;
            tgl_ff <= 1'b0;
        end
        else if (tgl_cnt_ff == TGL_CNT_W'(TOGGLE_HALF_P - 1))
        begin
            tgl_cnt_ff <= '0;
            tgl_ff <= !tgl_ff;
        end
        else
            tgl_cnt_ff <= tgl_cnt_ff + 1'b1;
    end

    // Level: low while busy; toggle: stack position while busy
    always_comb
    begin
        if (ctrl_ff[CTRL_LEVEL])
            drive_low = busy;
        else if (busy)
            drive_low = tos_s;
        else
            drive_low = tgl_ff;
    end

    // Pin only ever pulls low, released when unselected
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            sdo_oe_n_ff <= 1'b1;
        else
            sdo_oe_n_ff <= !(sel && drive_low);
    end

    assign serial_out_o = 1'b0;
    assign serial_out_oe_n_o = sdo_oe_n_ff;

    sdo_idle_a: assert property (!sel |=> serial_out_oe_n_o)
        else $error("serial pin driven while unselected");
    level_poll_a: assert property (sel && ctrl_ff[CTRL_LEVEL] && busy
        |=> !serial_out_oe_n_o)
        else $error("level poll not low while busy");
    tos_toggle_a: assert property (sel && !ctrl_ff[CTRL_LEVEL] && busy && !tos_s
        |=> serial_out_oe_n_o)
        else $error("lower device drove pin while busy");

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [1:0] irq_ff;  // Sticky events
    logic [1:0] mask_ff; // Enables
    logic [1:0] irq_set; // Events this cycle
    logic [1:0] irq_clr; // Write-one-to-clear

    assign irq_set = {temp_done, wdog_exp && !wdog_d_ff};
    assign irq_clr = (wr && (apb_i.paddr == OFS_IRQ)) ? apb_i.pwdata[1:0] : 2'h0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            irq_ff <= IRQ_RST;
        else
            irq_ff <= (irq_ff & ~irq_clr) | irq_set;
    end

    // Mask register
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            mask_ff <= IRQ_RST;
        else if (wr && (apb_i.paddr == OFS_MASK))
            mask_ff <= apb_i.pwdata[1:0];
    end

    assign irq_o = |(irq_ff & mask_ff);

    // ************************************************************
    // Read data, captured in the setup cycle
    // ************************************************************
    logic [31:0] prdata_ff; // Registered read data

    // Select register by offset
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            prdata_ff <= 32'h0;
        else if (setup)
        begin
            unique case (apb_i.paddr)
                OFS_CTRL: prdata_ff <= {29'h0, ctrl_ff[CTRL_LEVEL], pin_lvl};
                OFS_STAT: prdata_ff <= {25'h0, addr_ff, tos_s, wpin_s, wdog_exp};
                OFS_IRQ: prdata_ff <= {30'h0, irq_ff};
                OFS_MASK: prdata_ff <= {30'h0, mask_ff};
                OFS_TEMP: prdata_ff <= {4'h0, temp_ff[23:12], 4'h0, temp_ff[11:0]};
                default: prdata_ff <= 32'h0;
            endcase
        end
    end

    assign prdata_o = prdata_ff;

    pin_read_a: assert property (setup && apb_i.paddr == OFS_CTRL && !ctrl_ff[0]
        |=> prdata_o[0] == 1'b0)
        else $error("pulled-down pin read as one");

    // ************************************************************
    // Scenario coverage
    // ************************************************************
    wdog_fire_c: cover property ($rose(wdog_exp));
    temp_run_c: cover property (temp_done);
    toggle_edge_c: cover property (sel && !busy && $changed(tgl_ff));
    gpio_read_c: cover property (setup && apb_i.paddr == OFS_CTRL && ctrl_ff[0]);

endmodule : monitor_pin_control_logic

`default_nettype wire

/* File: bench/host_side_model.sv */
// Purpose: Host side of the serial port, with the line pull-up
// Assumes: Bench drives select and command requests by NBA
// Notes: Released serial line reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none

module host_side_model (
    input wire logic sel_i,
    input wire logic kick_i,
    input wire logic sd_i,
    input wire logic sd_oe_n_i,
    output logic chip_select_n_o,
    output logic cmd_valid_o,
    output logic serial_level_o
);
    // Low select addresses the device
    assign chip_select_n_o = ~sel_i;
    // One-cycle valid command pulse
    assign cmd_valid_o = kick_i;
    // Pull-up when the device lets go
    assign serial_level_o = sd_oe_n_i ? 1'b1 : sd_i;
endmodule : host_side_model

`default_nettype wire

/* File: bench/test_monitor_pin_control_logic.sv */
// Purpose: Self-checking bench for the pin control block
// Assumes: Short watchdog and toggle counts set below
// Notes: Pins resolved from enables and external pull-ups
`timescale 1ns/1ps
`default_nettype none

module test_monitor_pin_control_logic;
    import pin_ctl_pkg::*;
    localparam int WD = 2000; // Short watchdog
    localparam int TH = 8; // Short toggle half period
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    apb_req_t apb = '0;
    adc_res_t adc = '0;
    logic busy = 1'b0, top_of_stack_sel = 1'b0, sel = 1'b0, kick = 1'b0;
    logic [3:0] strap = 4'h0;
    logic [1:0] ext = 2'h3; // External pin levels
    logic [31:0] prdata, rd;
    logic pready, pslverr, req, chan, wd_o, wd_oe_n, cs_n, cmd_v, sd, sd_oe_n, sd_lvl, irq, err;
    logic [1:0] gp_o, gp_oe_n;
    logic [3:0] dev_addr;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;
    wire logic wd_lvl = wd_oe_n ? 1'b1 : wd_o;
    wire logic [1:0] gp_lvl = (gp_oe_n & ext) | (~gp_oe_n & gp_o);

    always #5 clock_i = ~clock_i;

    monitor_pin_control_logic #(.WDOG_CYCLES_P(WD), .TOGGLE_HALF_P(TH)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmd_valid_i(cmd_v),
        .monitor_busy_i(busy), .adc_i(adc), .temp_conv_req_o(req),
        .temp_conv_chan_o(chan), .watchdog_alarm_n_i(wd_lvl), .watchdog_alarm_n_o(wd_o),
        .watchdog_alarm_n_oe_n_o(wd_oe_n), .general_pin_i(gp_lvl), .general_pin_o(gp_o),
        .general_pin_oe_n_o(gp_oe_n), .addr_strap_i(strap), .dev_addr_o(dev_addr),
        .top_of_stack_sel_i(top_of_stack_sel), .chip_select_n_i(cs_n), .serial_out_o(sd),
        .serial_out_oe_n_o(sd_oe_n), .irq_o(irq)
    );

    host_side_model host_u (
        .sel_i(sel), .kick_i(kick), .sd_i(sd), .sd_oe_n_i(sd_oe_n),
        .chip_select_n_o(cs_n), .cmd_valid_o(cmd_v), .serial_level_o(sd_lvl)
    );

    // ADC answers each request one cycle later
    always @(posedge clock_i)
    begin
        adc <= '{done: req, chan: chan, data: chan ? 12'hB2C : 12'h3D1};
    end

    // Hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask : tick

    // One APB transfer, held until pready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock_i);
        apb.penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask : bus

    task automatic pulse_kick();
        kick <= 1'b1;
        tick(1);
        kick <= 1'b0;
    endtask : pulse_kick

    task automatic t_pins();
        pulse_kick();
        bus(1'b1, OFS_CTRL, 32'h0);
        tick(1);
        check("pin_pull", gp_oe_n, 2'h0);
        tick(3);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("pin_read_low", rd, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h3);
        ext <= 2'h2;
        tick(4);
        check("pin_release", gp_oe_n, 2'h3);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("pin_read_ext", rd, 32'h2);
        ext <= 2'h3;
        bus(1'b0, 8'h1C, 32'h0);
        check("unmapped_rd", rd, 32'h0);
        check("unmapped_err", err, 1'b1);
    endtask : t_pins

    task automatic t_addr();
        strap <= 4'hA;
        tick(5);
        check("dev_addr", dev_addr, 4'hA);
        bus(1'b0, OFS_STAT, 32'h0);
        check("stat_addr", rd[6:3], 4'hA);
    endtask : t_addr

    task automatic t_temp();
        bus(1'b1, OFS_MASK, 32'h2);
        bus(1'b1, OFS_CMD, 32'h2);
        tick(1);
        check("conv_req", {req, chan}, 2'h2);
        n = 0;
        while (irq !== 1'b1 && n < 50)
        begin
            tick(1);
            n++;
        end
        bus(1'b0, OFS_TEMP, 32'h0);
        check("temp_result", rd, 32'h0B2C_03D1);
        bus(1'b0, OFS_IRQ, 32'h0);
        check("temp_event", rd, 32'h2);
        bus(1'b1, OFS_IRQ, 32'h2);
        tick(1);
        check("irq_clear", irq, 1'b0);
    endtask : t_temp

    task automatic t_serial();
        pulse_kick();
        bus(1'b1, OFS_CTRL, 32'h7);
        sel <= 1'b1;
        busy <= 1'b1;
        tick(5);
        check("level_busy", sd_lvl, 1'b0);
        busy <= 1'b0;
        tick(5);
        check("level_idle", sd_lvl, 1'b1);
        bus(1'b1, OFS_CTRL, 32'h3);
        top_of_stack_sel <= 1'b1;
        busy <= 1'b1;
        tick(5);
        check("toggle_top", sd_lvl, 1'b0);
        top_of_stack_sel <= 1'b0;
        tick(5);
        check("toggle_lower", sd_lvl, 1'b1);
        busy <= 1'b0;
        tick(5);
        n = 0;
        repeat (4 * TH)
        begin
            tick(1);
            n += int'(sd_lvl);
        end
        check("toggle_wave", n, 2 * TH);
        sel <= 1'b0;
        tick(5);
        n = 0;
        repeat (2 * TH)
        begin
            tick(1);
            n += int'(sd_lvl);
        end
        check("unselected", n, 2 * TH);
    endtask : t_serial

    task automatic t_wdog();
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_MASK, 32'h1);
        pulse_kick();
        n = 0;
        while (wd_oe_n !== 1'b0 && n < WD + 50)
        begin
            tick(1);
            n++;
        end
        check("wdog_delay", (n >= WD - 2 && n <= WD + 4), 1'b1);
        tick(2);
        check("wdog_defaults", {gp_oe_n, wd_lvl, irq}, 4'hD);
        bus(1'b0, OFS_STAT, 32'h0);
        check("wdog_stat", rd, 32'h51);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("wdog_ctrl_held", rd, 32'h3);
        pulse_kick();
        tick(2);
        check("wdog_release", wd_oe_n, 1'b1);
        bus(1'b1, OFS_IRQ, 32'h1);
        tick(1);
        check("wdog_irq_clear", irq, 1'b0);
    endtask : t_wdog

    initial
    begin
        tick(5);
        rst_n_i <= 1'b1;
        tick(3);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl_reset", rd, 32'h3);
        t_pins();
        t_addr();
        t_temp();
        t_serial();
        t_wdog();
        stop_test();
    end
endmodule : test_monitor_pin_control_logic

`default_nettype wire
